// File: core/clock_ctrl_pkg.sv
// package for the clock select and prescale block: register map, field layout, timing
// assumes a 125 MHz bus clock that also stands in for the undivided source clock
package clock_ctrl_pkg;

	// ==========================================================
	// register map (byte addresses on the bus)
	localparam logic [7:0] OFS_CLOCK_CONTROL = 8'h00;
	localparam logic [7:0] OFS_CLOCK_PRESCALE = 8'h04;
	localparam logic [7:0] OFS_CHANGE_PROTECTION = 8'h08;
	localparam logic [7:0] OFS_CLOCK_STATUS = 8'h0c;

	// ==========================================================
	// clock_control fields and prescale field widths
	localparam int BIT_OSC_READY = 7;
	localparam int BIT_SELECT_TRIGGER = 6;
	localparam int BIT_CLKOUT_COPY = 5;
	localparam int BIT_STARTUP_TIME = 4;
	localparam int SELECT_LSB = 0;
	localparam int SELECT_W = 4;
	localparam int PRESCALE_W = 4;
	localparam int PRESCALE_MAX_SHIFT = 8;

	// ==========================================================
	// source selections
	localparam logic [3:0] SEL_EXTERNAL = 4'h0;
	localparam logic [3:0] SEL_INTERNAL_8M = 4'h2;
	localparam logic [3:0] SEL_INTERNAL_LP = 4'h4;
	localparam logic [3:0] SEL_LF_CRYSTAL = 4'h6;

	// prescale reset values
	localparam logic [3:0] PRESCALE_DIV1 = 4'h0;
	localparam logic [3:0] PRESCALE_DIV8 = 4'h3;

	// ==========================================================
	// timing: clock rate and start-up times
	localparam int CLK_FREQ_KHZ = 125000;
	localparam int WAKE_SHORT_CK = 6;
	localparam int WAKE_258_CK = 258;
	localparam int WAKE_1K_CK = 1024;
	localparam int WAKE_16K_CK = 16384;
	localparam int WAKE_32K_CK = 32768;
	localparam int RESET_FIXED_CK = 14;
	localparam int RESET_EXTRA_MS = 16;
	localparam int RESET_EXTRA_CYC = RESET_EXTRA_MS * CLK_FREQ_KHZ;
	localparam int BROWNOUT_WAKE_US = 60;
	localparam int BROWNOUT_WAKE_CYC = (BROWNOUT_WAKE_US * CLK_FREQ_KHZ) / 1000;
	localparam int PROTECT_WINDOW_CYC = 4;
	localparam int DELAY_W = 22;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic clock_output;
		logic divide_by_eight;
		logic startup_time;
		logic [3:0] source_select;
	} fuses_s;

	typedef struct packed {
		logic osc_ready;
		logic select_trigger;
		logic clkout_copy;
		logic startup_time;
		logic [3:0] source_select;
	} clock_control_s;

	typedef enum logic [1:0] {
		ST_RESET_WAIT = 2'b00,
		ST_RUN = 2'b01,
		ST_WAKE_WAIT = 2'b11
	} run_state_e;

endpackage : clock_ctrl_pkg

// File: core/system_clock_select_prescale.sv
// clock select, start-up timing and system clock prescaler with an ahb-lite register slave
// assumes hclk is the undivided source clock; fuse inputs are steady; wake_request is a pulse
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps

module system_clock_select_prescale #(
	parameter logic [7:0] CHANGE_SIGNATURE = 8'h5a, // arbitrary value
	parameter int PROTECT_WINDOW = clock_ctrl_pkg::PROTECT_WINDOW_CYC,
	parameter int WAKE_16K = clock_ctrl_pkg::WAKE_16K_CK,
	parameter int WAKE_32K = clock_ctrl_pkg::WAKE_32K_CK,
	parameter int RESET_EXTRA = clock_ctrl_pkg::RESET_EXTRA_CYC,
	parameter int BROWNOUT_WAKE = clock_ctrl_pkg::BROWNOUT_WAKE_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire clock_ctrl_pkg::fuses_s fuses,
	input wire logic wake_request,
	input wire logic brownout_detector_disabled,
	output logic system_clock_en,
	output logic cpu_run,
	output logic [3:0] active_source,
	output logic [3:0] enabled_source,
	output logic clock_output_pin_o,
	output logic clock_output_pin_oe
);

	// ==========================================================
	// start-up delay per selection, in source cycles
	function automatic logic [clock_ctrl_pkg::DELAY_W-1:0] wake_delay(input logic [3:0] sel, input logic startup_time_select);
		int n;
		n = clock_ctrl_pkg::WAKE_SHORT_CK;
		if (sel == clock_ctrl_pkg::SEL_LF_CRYSTAL)
			n = startup_time_select ? WAKE_32K : clock_ctrl_pkg::WAKE_1K_CK;
		else if (sel[3])
		begin
			if (sel[0])
				n = WAKE_16K;
			else
				n = startup_time_select ? clock_ctrl_pkg::WAKE_1K_CK : clock_ctrl_pkg::WAKE_258_CK;
		end
		// external, internal and reserved codes take the short count; reserved is unsupported
		wake_delay = n[clock_ctrl_pkg::DELAY_W-1:0];
	endfunction : wake_delay

	// division shift for a prescale code; reserved codes clamp to the largest division
	function automatic logic [3:0] prescale_shift(input logic [3:0] code);
		if (code > 4'h8)
			prescale_shift = 4'h8;
		else
			prescale_shift = code;
	endfunction : prescale_shift

	// ==========================================================
	// bus slave
	logic dp_write_q, dp_read_q, rd_wait_q;
	logic [7:0] dp_addr_q;
	logic [31:0] hrdata_q;
	logic addr_phase;

	assign addr_phase = hsel && hready && htrans[1];
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;
	// reads take one wait state so a write just before is always seen
	assign hreadyout = !(dp_read_q && rd_wait_q);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_write_q <= 1'b0;
			dp_read_q <= 1'b0;
			dp_addr_q <= 8'h00;
		end
		else if (hreadyout)
		begin
			dp_write_q <= addr_phase && hwrite;
			dp_read_q <= addr_phase && !hwrite;
			dp_addr_q <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rd_wait_q <= 1'b0;
		else
			rd_wait_q <= addr_phase && !hwrite && hreadyout;
	end

	logic wr_ctrl, wr_presc, wr_key;
	assign wr_ctrl = dp_write_q && dp_addr_q == clock_ctrl_pkg::OFS_CLOCK_CONTROL;
	assign wr_presc = dp_write_q && dp_addr_q == clock_ctrl_pkg::OFS_CLOCK_PRESCALE;
	assign wr_key = dp_write_q && dp_addr_q == clock_ctrl_pkg::OFS_CHANGE_PROTECTION;

	// ==========================================================
	// change protection window
	logic [3:0] window_q;
	logic unlocked;
	assign unlocked = window_q != 4'h0;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			window_q <= 4'h0;
		else if (wr_key && hwdata[7:0] == CHANGE_SIGNATURE)
			window_q <= 4'(PROTECT_WINDOW);
		else if (unlocked)
			window_q <= window_q - 4'h1;
	end

	// ==========================================================
	// fuse load one cycle after reset release; flops hold constants under reset
	logic loaded_q;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			loaded_q <= 1'b0;
		else
			loaded_q <= 1'b1;
	end

	// ==========================================================
	// clock control register
	logic [3:0] select_q, active_q;
	logic sut_q, clkout_q, osc_ready_q;
	logic ctrl_ok;
	assign ctrl_ok = wr_ctrl && unlocked;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			select_q <= 4'h0;
			active_q <= 4'h0;
			sut_q <= 1'b0;
			clkout_q <= 1'b0;
		end
		else if (!loaded_q)
		begin
			select_q <= fuses.source_select;
			active_q <= fuses.source_select;
			sut_q <= fuses.startup_time;
			clkout_q <= fuses.clock_output;
		end
		else if (ctrl_ok)
		begin
			select_q <= hwdata[clock_ctrl_pkg::SELECT_LSB +: clock_ctrl_pkg::SELECT_W];
			sut_q <= hwdata[clock_ctrl_pkg::BIT_STARTUP_TIME];
			clkout_q <= hwdata[clock_ctrl_pkg::BIT_CLKOUT_COPY];
			if (hwdata[clock_ctrl_pkg::BIT_SELECT_TRIGGER])
				active_q <= hwdata[clock_ctrl_pkg::SELECT_LSB +: clock_ctrl_pkg::SELECT_W];
		end
	end

	assign active_source = active_q;
	assign enabled_source = select_q;

	// ==========================================================
	// run state and start-up timer
	clock_ctrl_pkg::run_state_e state_q;
	logic [clock_ctrl_pkg::DELAY_W-1:0] delay_q;
	logic [clock_ctrl_pkg::DELAY_W-1:0] osc_cnt_q;
	logic [clock_ctrl_pkg::DELAY_W-1:0] wake_len;

	always_comb
	begin
		wake_len = wake_delay(active_q, sut_q);
		if (brownout_detector_disabled && wake_len < clock_ctrl_pkg::DELAY_W'(BROWNOUT_WAKE))
			wake_len = clock_ctrl_pkg::DELAY_W'(BROWNOUT_WAKE);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_q <= clock_ctrl_pkg::ST_RESET_WAIT;
			delay_q <= '0;
		end
		else
		begin
			case (state_q)
				clock_ctrl_pkg::ST_RESET_WAIT:
				begin
					// fixed cycles plus the supply settling wait
					if (delay_q == clock_ctrl_pkg::DELAY_W'(clock_ctrl_pkg::RESET_FIXED_CK + RESET_EXTRA - 1))
					begin
						state_q <= clock_ctrl_pkg::ST_RUN;
						delay_q <= '0;
					end
					else
						delay_q <= delay_q + 1'b1;
				end
				clock_ctrl_pkg::ST_RUN:
				begin
					if (wake_request)
					begin
						state_q <= clock_ctrl_pkg::ST_WAKE_WAIT;
						delay_q <= '0;
					end
				end
				clock_ctrl_pkg::ST_WAKE_WAIT:
				begin
					if (delay_q >= wake_len - 1'b1)
					begin
						state_q <= clock_ctrl_pkg::ST_RUN;
						delay_q <= '0;
					end
					else
						delay_q <= delay_q + 1'b1;
				end
				default:
				begin
					state_q <= clock_ctrl_pkg::ST_RESET_WAIT;
					delay_q <= '0;
				end
			endcase
		end
	end

	assign cpu_run = state_q == clock_ctrl_pkg::ST_RUN;

	// oscillator time-out for the enabled source; restarts when a new source is enabled
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			osc_cnt_q <= '0;
			osc_ready_q <= 1'b0;
		end
		else if (!loaded_q || (ctrl_ok &&
			hwdata[clock_ctrl_pkg::SELECT_LSB +: clock_ctrl_pkg::SELECT_W] != select_q))
		begin
			osc_cnt_q <= '0;
			osc_ready_q <= 1'b0;
		end
		else if (!osc_ready_q)
		begin
			if (osc_cnt_q >= wake_delay(select_q, sut_q) - 1'b1)
				osc_ready_q <= 1'b1;
			else
				osc_cnt_q <= osc_cnt_q + 1'b1;
		end
	end

	// ==========================================================
	// prescaler: free count on the source clock, new setting taken at an old period end
	logic [3:0] presc_q, presc_act_q;
	logic presc_pend_q;
	logic [7:0] ripple_q;
	logic [7:0] mask;
	logic period_end;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			presc_q <= clock_ctrl_pkg::PRESCALE_DIV1;
			presc_pend_q <= 1'b0;
		end
		else if (!loaded_q)
		begin
			presc_q <= fuses.divide_by_eight ? clock_ctrl_pkg::PRESCALE_DIV8 : clock_ctrl_pkg::PRESCALE_DIV1;
			presc_pend_q <= 1'b1;
		end
		else if (wr_presc && unlocked)
		begin
			presc_q <= hwdata[clock_ctrl_pkg::PRESCALE_W-1:0];
			presc_pend_q <= 1'b1;
		end
		else if (period_end)
			presc_pend_q <= 1'b0;
	end

	always_comb
	begin
		mask = 8'hff >> (4'(clock_ctrl_pkg::PRESCALE_MAX_SHIFT) - prescale_shift(presc_act_q));
		if (prescale_shift(presc_act_q) == 4'h0)
			mask = 8'h00;
	end

	assign period_end = (ripple_q & mask) == mask;

	// switching only at the end of a whole old period and restarting the count avoids
	// any short pulse: the old period completes, then whole new periods follow
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ripple_q <= 8'h00;
			presc_act_q <= clock_ctrl_pkg::PRESCALE_DIV1;
		end
		else if (period_end && presc_pend_q)
		begin
			ripple_q <= 8'h00;
			presc_act_q <= presc_q;
		end
		else
			ripple_q <= ripple_q + 8'h01;
	end

	// one enable for the io, adc, cpu and flash domains
	assign system_clock_en = period_end;

	// ==========================================================
	// clock output pin: high for the first half of each divided period, and high all the time when undivided
	logic pin_level;
	always_comb
	begin
		if (mask == 8'h00)
			pin_level = 1'b1;
		else
			pin_level = (ripple_q & mask) <= (mask >> 1);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			clock_output_pin_o <= 1'b0;
			clock_output_pin_oe <= 1'b0;
		end
		else
		begin
			clock_output_pin_o <= clkout_q && loaded_q && pin_level;
			clock_output_pin_oe <= clkout_q && loaded_q;
		end
	end

	// ==========================================================
	// read mux, sampled in the wait cycle of a read
	clock_ctrl_pkg::clock_control_s ctrl_rd;
	logic [31:0] rd_mux;

	always_comb
	begin
		ctrl_rd.osc_ready = osc_ready_q;
		ctrl_rd.select_trigger = 1'b0;
		ctrl_rd.clkout_copy = clkout_q;
		ctrl_rd.startup_time = sut_q;
		ctrl_rd.source_select = select_q;
		case (dp_addr_q)
			clock_ctrl_pkg::OFS_CLOCK_CONTROL:
				rd_mux = {24'h000000, ctrl_rd};
			clock_ctrl_pkg::OFS_CLOCK_PRESCALE:
				rd_mux = {28'h0000000, presc_q};
			clock_ctrl_pkg::OFS_CLOCK_STATUS:
				rd_mux = {20'h00000, active_q, presc_act_q, 1'b0, presc_pend_q, state_q};
			default:
				rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_q <= 32'h00000000;
		else if (dp_read_q && rd_wait_q)
			hrdata_q <= rd_mux;
	end

endmodule : system_clock_select_prescale

// File: sim/system_clock_select_prescale_chk.sv
// concurrent checks on the ports of the clock select and prescale block
// assumes one slave on the bus (hready is its own hreadyout) and low-byte decode
`timescale 1ns/100ps

module system_clock_select_prescale_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic wake_request,
	input wire logic brownout_detector_disabled,
	input wire logic cpu_run,
	input wire logic [3:0] active_source,
	input wire logic [3:0] enabled_source,
	input wire logic clock_output_pin_o,
	input wire logic clock_output_pin_oe
);
	// ==========================================================
	// helpers
	logic wr_ctl_q;
	logic [1:0] up_q;

	// marks the data phase of a write to clock_control
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wr_ctl_q <= 1'b0;
		else if (hready)
			wr_ctl_q <= hsel && htrans[1] && hwrite && haddr[7:0] == clock_ctrl_pkg::OFS_CLOCK_CONTROL;
	end

	// fuse load after reset changes sources legitimately, so skip the first edges
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			up_q <= 2'h0;
		else if (up_q != 2'h3)
			up_q <= up_q + 2'h1;
	end

	// ==========================================================
	// properties
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_read_wait:
		assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read did not take exactly one wait state");
	a_write_fast:
		assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	a_resp_okay:
		assert property (!hresp)
		else $error("bus response not okay");
	a_pin_quiet:
		assert property ($rose(hresetn) |-> !clock_output_pin_oe && !clock_output_pin_o)
		else $error("clock output active out of reset");
	a_active_hold:
		assert property (up_q == 2'h3 && $changed(active_source) |-> $past(wr_ctl_q))
		else $error("active source changed without a control write");
	a_enabled_hold:
		assert property (up_q == 2'h3 && $changed(enabled_source) |-> $past(wr_ctl_q))
		else $error("enabled source changed without a control write");
	a_wake_drop:
		assert property (wake_request && cpu_run |=> !cpu_run)
		else $error("wake event did not stop the cpu");
	a_wake_short:
		assert property (wake_request && cpu_run && active_source == clock_ctrl_pkg::SEL_INTERNAL_8M
			&& !brownout_detector_disabled |=> !cpu_run [*6] ##1 cpu_run)
		else $error("short wake delay not six cycles");
endmodule : system_clock_select_prescale_chk

// File: sim/system_clock_select_prescale_tb_top.sv
// self-checking bench for the clock select and prescale block
// assumes the checker file is compiled before this one; long counts shortened by parameter
`timescale 1ns/100ps

module system_clock_select_prescale_tb_top;
	localparam logic [7:0] ctl_a = clock_ctrl_pkg::OFS_CLOCK_CONTROL;
	localparam logic [7:0] pre_a = clock_ctrl_pkg::OFS_CLOCK_PRESCALE;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hready;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	clock_ctrl_pkg::fuses_s fuses = 7'h62;
	logic wake_request = 1'b0;
	logic brownout_detector_disabled = 1'b0;
	logic system_clock_en;
	logic cpu_run;
	logic [3:0] active_source;
	logic [3:0] enabled_source;
	logic clock_output_pin_o;
	logic clock_output_pin_oe;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	logic [31:0] d;

	assign hready = hreadyout;
	always #4 hclk = ~hclk;

	system_clock_select_prescale #(.RESET_EXTRA(20), .WAKE_16K(16), .WAKE_32K(32), .BROWNOUT_WAKE(10))
	system_clock_select_prescale_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .fuses(fuses), .wake_request(wake_request),
		.brownout_detector_disabled(brownout_detector_disabled), .system_clock_en(system_clock_en),
		.cpu_run(cpu_run), .active_source(active_source), .enabled_source(enabled_source),
		.clock_output_pin_o(clock_output_pin_o), .clock_output_pin_oe(clock_output_pin_oe));

	// ==========================================================
	// shared tasks
	task test_done;
	begin
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask : test_done

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
	begin
		compares++;
		if (s !== e)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	end
	endtask : chk

	// each phase is held until hready is seen high at a rising edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
	begin
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwrite <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
	end
	endtask : xfer

	// signature then the protected write, back to back
	task pwr(input logic [7:0] a, input logic [31:0] wd);
	begin
		xfer(1'b1, clock_ctrl_pkg::OFS_CHANGE_PROTECTION, 32'h5a);
		xfer(1'b1, a, wd);
		@(posedge hclk);
	end
	endtask : pwr

	task wake(input int e);
		int n;
	begin
		wake_request <= 1'b1;
		@(posedge hclk);
		wake_request <= 1'b0;
		n = 0;
		@(posedge hclk);
		while (cpu_run !== 1'b1)
		begin
			n++;
			@(posedge hclk);
		end
		chk("wake delay", n, e);
	end
	endtask : wake

	// ==========================================================
	// scenarios
	task t_boot;
		int n;
	begin
		n = 0;
		while (cpu_run !== 1'b1)
		begin
			n++;
			@(posedge hclk);
		end
		chk("boot delay", n, clock_ctrl_pkg::RESET_FIXED_CK + 20);
		xfer(1'b0, ctl_a, 0);
		chk("control reset", d & 32'h7f, 32'h22);
		chk("select fuse", d & 32'h1f, 32'h02);
		xfer(1'b0, pre_a, 0);
		chk("prescale reset", d, 32'h3);
		xfer(1'b0, clock_ctrl_pkg::OFS_CLOCK_STATUS, 0);
		chk("status after boot", d, 32'h231);
		chk("pin enable", clock_output_pin_oe, 1'b1);
	end
	endtask : t_boot

	task t_prescale;
		int n;
		int h;
	begin
		xfer(1'b1, pre_a, 32'h1);
		xfer(1'b0, pre_a, 0);
		chk("unprotected write", d, 32'h3);
		for (int c = 0; c <= 8; c++)
		begin
			pwr(pre_a, 32'hf0 | c);
			xfer(1'b0, pre_a, 0);
			chk("prescale read", d, c);
			// the switch moment is not predictable, so let it settle first
			repeat (300) @(posedge hclk);
			while (system_clock_en !== 1'b1) @(posedge hclk);
			n = 0;
			h = 0;
			do
			begin
				@(posedge hclk);
				n++;
				h += clock_output_pin_o;
			end
			while (system_clock_en !== 1'b1);
			chk("divided period", n, 1 << c);
			chk("pin high time", h, c == 0 ? 1 : (1 << c) / 2);
		end
	end
	endtask : t_prescale

	task t_select;
	begin
		pwr(ctl_a, 32'h26);
		chk("enabled source", enabled_source, 4'h6);
		chk("kept source", active_source, 4'h2);
		xfer(1'b0, ctl_a, 0);
		chk("ready cleared", d[7], 1'b0);
		repeat (1100) @(posedge hclk);
		xfer(1'b0, ctl_a, 0);
		chk("ready set", d[7], 1'b1);
		pwr(ctl_a, 32'h76);
		chk("switched source", active_source, 4'h6);
	end
	endtask : t_select

	task t_wake;
	begin
		wake(32);
		pwr(ctl_a, 32'h66);
		wake(1024);
		pwr(ctl_a, 32'h62);
		wake(6);
		brownout_detector_disabled <= 1'b1;
		wake(10);
		brownout_detector_disabled <= 1'b0;
		pwr(ctl_a, 32'h68);
		wake(258);
		pwr(ctl_a, 32'h69);
		wake(16);
	end
	endtask : t_wake

	task t_unmapped;
	begin
		xfer(1'b0, 8'h10, 0);
		chk("unmapped read", d, 32'h0);
		pwr(8'h10, 32'hff);
		xfer(1'b0, ctl_a, 0);
		chk("control after stray write", d & 32'h7f, 32'h29);
		xfer(1'b1, ctl_a, 32'h60);
		xfer(1'b0, ctl_a, 0);
		chk("control after unsigned write", d & 32'h7f, 32'h29);
		// signature written, then the window is left to run out before the write
		xfer(1'b1, clock_ctrl_pkg::OFS_CHANGE_PROTECTION, 32'h5a);
		repeat (clock_ctrl_pkg::PROTECT_WINDOW_CYC + 2) @(posedge hclk);
		xfer(1'b1, ctl_a, 32'h60);
		xfer(1'b0, ctl_a, 0);
		chk("control after late write", d & 32'h7f, 32'h29);
	end
	endtask : t_unmapped

	// reset in mid-run: pin silenced, then every fuse copy reloaded
	task t_reset;
	begin
		while (clock_output_pin_o !== 1'b1) @(posedge hclk);
		hresetn <= 1'b0;
		@(posedge hclk);
		chk("pin enable in reset", clock_output_pin_oe, 1'b0);
		chk("pin level in reset", clock_output_pin_o, 1'b0);
		repeat (19) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_boot;
	end
	endtask : t_reset

	// ==========================================================
	// main sequence and hang guard
	always @(posedge hclk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			failures++;
			test_done;
		end
	end

	initial
	begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_boot;
		t_prescale;
		t_select;
		t_wake;
		t_unmapped;
		t_reset;
		test_done;
	end
endmodule : system_clock_select_prescale_tb_top

bind system_clock_select_prescale system_clock_select_prescale_chk system_clock_select_prescale_chk_inst (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .wake_request(wake_request),
	.brownout_detector_disabled(brownout_detector_disabled), .cpu_run(cpu_run),
	.active_source(active_source), .enabled_source(enabled_source),
	.clock_output_pin_o(clock_output_pin_o), .clock_output_pin_oe(clock_output_pin_oe));
